// ### gfc_pkg.sv
package gfc_pkg;
	localparam int CH_N = 4;
	localparam int CNT_W = 16;
	localparam int PRE_W = 3;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;
	localparam logic [5:0] IDX_MODE = 6'h00;
	localparam logic [5:0] IDX_FORCE = 6'h01;
	localparam logic [5:0] IDX_MASK = 6'h02;
	localparam logic [5:0] IDX_DATA = 6'h03;
	localparam logic [5:0] IDX_COUNT = 6'h04;
	localparam logic [5:0] IDX_TOV = 6'h07;
	localparam logic [5:0] IDX_PORT = 6'h1C;
	localparam logic [5:0] IDX_DDR = 6'h1D;
	localparam logic [5:0] IDX_TEST = 6'h1E;
	localparam logic [5:0] IDX_CTRL = 6'h20;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h21;
	localparam logic [5:0] IDX_IRQ_CLR = 6'h22;
	localparam logic [5:0] IDX_IRQ_EN = 6'h23;
	localparam int TEST_MODE_BIT = 0;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PRE_LSB = 1;
	localparam int IRQ_N = 3;
	localparam int IRQ_CH3 = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_FORCE = 2;
	localparam logic [3:0] CH_RESET = 4'h0;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	typedef enum logic [1:0] {
		GFC_ACT_NONE = 2'h0,
		GFC_ACT_TOGGLE = 2'h1,
		GFC_ACT_CLEAR = 2'h2,
		GFC_ACT_SET = 2'h3
	} gfc_action_e;
endpackage : gfc_pkg

// ### gfc_prescaler.sv
`timescale 1ns/1ns
module gfc_prescaler #(
	parameter int PRE_W = 3
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic restart,
	input wire logic [PRE_W-1:0] sel,
	output logic tick
);
	localparam int DIV_W = (1 << PRE_W) - 1;
	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] mask;
	wire atEnd;
	if (PRE_W < 1 || PRE_W > 4) begin : g_bad_width
		$error("prescaler select width out of range");
	end
	assign mask = DIV_W'((1 << sel) - 1);
	assign atEnd = ((div & mask) == mask);
	// restart realigns the divider so a forced load is not split
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div <= '0;
			tick <= 1'b0;
		end else if (restart || !enable) begin
			div <= '0;
			tick <= 1'b0;
		end else begin
			div <= atEnd ? '0 : div + 1'b1;
			tick <= atEnd;
		end
	end
endmodule : gfc_prescaler

// ### gfc_counter.sv
`timescale 1ns/1ns
module gfc_counter #(
	parameter int CNT_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic load,
	input wire logic [CNT_W-1:0] loadValue,
	output logic [CNT_W-1:0] count,
	output logic overflow
);
	if (CNT_W < 2) begin : g_bad_width
		$error("counter width too small");
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			overflow <= 1'b0;
		end else if (load) begin
			count <= loadValue;
			overflow <= 1'b0;
		end else begin
			count <= tick ? count + 1'b1 : count;
			overflow <= tick & (&count);
		end
	end
endmodule : gfc_counter

// ### gfc_force_compare.sv
`timescale 1ns/1ns
// What this block does
// - writing one to a low force bit fires that channel's compare action
// - forced compare drives the pin and the force interrupt status bit, never the compare flag
// - channel 3 compare overrides simultaneous pin actions on every channel whose mask bit is set
// - set mask bit makes the port pin output while channel compares
// - mask bits never alter stored direction bits
// - channel 3 compare copies masked data bits into port data
// - force, mask, data registers read/write anytime; upper 28 bits reserved
// - counter register reads the live 16-bit count anytime
// - counter writes only take effect in test mode
// - test-mode counter write restarts the prescaler; first count takes a full prescaler period
// - mode bit one selects output compare, zero input capture
// - overflow toggle beats forced compare, yields to channel 3 override
module gfc_force_compare (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [gfc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [gfc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [gfc_pkg::CH_N-1:0] compareMatch,
	input wire logic [2*gfc_pkg::CH_N-1:0] compareAction,
	input wire logic [gfc_pkg::CH_N-1:0] timerPortPinIn,
	output logic [gfc_pkg::CH_N-1:0] timerPortPinOut,
	output logic [gfc_pkg::CH_N-1:0] timerPortPinOe,
	output logic [gfc_pkg::CH_N-1:0] compareFlagSet,
	output logic [gfc_pkg::CNT_W-1:0] countValueField,
	output logic irq
);
	localparam int N = gfc_pkg::CH_N;
	localparam int CW = gfc_pkg::CNT_W;
	localparam int PW = gfc_pkg::PRE_W;

	logic [N-1:0] channelModeSelect;
	logic [N-1:0] forceCompareBits;
	logic [N-1:0] channel3OverrideMaskBits;
	logic [N-1:0] channel3OverrideDataBits;
	logic [N-1:0] toggleOnOverflowEnable;
	logic [N-1:0] timerPortDirectionBits;
	logic testMode;
	logic timerEnable;
	logic [PW-1:0] prescaleSel;
	logic [gfc_pkg::IRQ_N-1:0] irqStatus;
	logic [gfc_pkg::IRQ_N-1:0] irqEnable;
	logic [gfc_pkg::ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic [CW-1:0] count;
	logic overflow;
	logic tick;

	// write channel: both beats are held, then committed together
	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire wrFire = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
	wire [gfc_pkg::IDX_W-1:0] wrIdx = awAddr[gfc_pkg::IDX_LSB +: gfc_pkg::IDX_W];
	wire wrLo = wrFire & wStrb[0];
	wire wrMode = wrLo & (wrIdx == gfc_pkg::IDX_MODE);
	wire wrForce = wrLo & (wrIdx == gfc_pkg::IDX_FORCE);
	wire wrMask = wrLo & (wrIdx == gfc_pkg::IDX_MASK);
	wire wrData = wrLo & (wrIdx == gfc_pkg::IDX_DATA);
	wire wrTov = wrLo & (wrIdx == gfc_pkg::IDX_TOV);
	wire wrPort = wrLo & (wrIdx == gfc_pkg::IDX_PORT);
	wire wrDdr = wrLo & (wrIdx == gfc_pkg::IDX_DDR);
	wire wrTest = wrLo & (wrIdx == gfc_pkg::IDX_TEST);
	wire wrCtrl = wrLo & (wrIdx == gfc_pkg::IDX_CTRL);
	wire wrIrqClr = wrLo & (wrIdx == gfc_pkg::IDX_IRQ_CLR);
	wire wrIrqEn = wrLo & (wrIdx == gfc_pkg::IDX_IRQ_EN);
	// a partial-lane counter write is dropped rather than half-loaded
	wire wrCount = wrFire & (wrIdx == gfc_pkg::IDX_COUNT) & (&wStrb[1:0]);
	wire countLoad = wrCount & testMode;
	wire [N-1:0] wrLow = wData[N-1:0];

	// read channel
	wire arTake = s_axi_arvalid & s_axi_arready;
	wire [gfc_pkg::IDX_W-1:0] rdIdx =
		s_axi_araddr[gfc_pkg::IDX_LSB +: gfc_pkg::IDX_W];
	wire [31:0] rdMode = {28'h0000000, channelModeSelect};
	wire [31:0] rdForce = {28'h0000000, forceCompareBits};
	wire [31:0] rdMask = {28'h0000000, channel3OverrideMaskBits};
	wire [31:0] rdData = {28'h0000000, channel3OverrideDataBits};
	wire [31:0] rdCount = {16'h0000, count};
	wire [31:0] rdTov = {28'h0000000, toggleOnOverflowEnable};
	wire [31:0] rdPort = {28'h0000000, timerPortPinOut};
	wire [31:0] rdDdr = {28'h0000000, timerPortDirectionBits};
	wire [31:0] rdTest = {31'h0, testMode};
	wire [31:0] rdCtrl = {28'h0000000, prescaleSel, timerEnable};
	wire [31:0] rdStat = {29'h0, irqStatus};
	wire [31:0] rdIrqEn = {29'h0, irqEnable};
	wire [31:0] readMux =
		(rdIdx == gfc_pkg::IDX_MODE) ? rdMode :
		(rdIdx == gfc_pkg::IDX_FORCE) ? rdForce :
		(rdIdx == gfc_pkg::IDX_MASK) ? rdMask :
		(rdIdx == gfc_pkg::IDX_DATA) ? rdData :
		(rdIdx == gfc_pkg::IDX_COUNT) ? rdCount :
		(rdIdx == gfc_pkg::IDX_TOV) ? rdTov :
		(rdIdx == gfc_pkg::IDX_PORT) ? rdPort :
		(rdIdx == gfc_pkg::IDX_DDR) ? rdDdr :
		(rdIdx == gfc_pkg::IDX_TEST) ? rdTest :
		(rdIdx == gfc_pkg::IDX_CTRL) ? rdCtrl :
		(rdIdx == gfc_pkg::IDX_IRQ_STAT) ? rdStat :
		(rdIdx == gfc_pkg::IDX_IRQ_EN) ? rdIrqEn : 32'h00000000;

	// compare and pin logic
	wire [N-1:0] forceStrobe = wrForce ? wrLow : '0;
	wire ch3Fire = compareMatch[N-1] & channelModeSelect[N-1];
	logic [N-1:0] overrideHit;
	logic [N-1:0] tovHit;
	logic [N-1:0] cmpHit;
	logic [N-1:0] nextPort;
	wire [N-1:0] nextOe = timerPortDirectionBits |
		(channel3OverrideMaskBits & channelModeSelect);
	wire [N-1:0] nextFlag = compareMatch & channelModeSelect;

	function automatic logic applyAction(input logic [1:0] act,
		input logic cur);
		case (gfc_pkg::gfc_action_e'(act))
			gfc_pkg::GFC_ACT_TOGGLE: applyAction = ~cur;
			gfc_pkg::GFC_ACT_CLEAR: applyAction = 1'b0;
			gfc_pkg::GFC_ACT_SET: applyAction = 1'b1;
			default: applyAction = cur;
		endcase
	endfunction : applyAction

	genvar n;
	generate
		for (n = 0; n < N; n++) begin : g_ch
			assign overrideHit[n] = ch3Fire & channel3OverrideMaskBits[n];
			assign tovHit[n] = channelModeSelect[n] & toggleOnOverflowEnable[n] &
				overflow;
			assign cmpHit[n] = channelModeSelect[n] &
				(forceStrobe[n] | compareMatch[n]);
			// override first, then overflow toggle, then compare action
			assign nextPort[n] =
				overrideHit[n] ? channel3OverrideDataBits[n] :
				tovHit[n] ? ~timerPortPinOut[n] :
				cmpHit[n] ?
					applyAction(compareAction[2*n +: 2], timerPortPinOut[n]) :
				wrPort ? wrLow[n] : timerPortPinOut[n];
		end
	endgenerate

	// interrupt events: set wins over a clear in the same cycle
	wire [gfc_pkg::IRQ_N-1:0] irqEvent = {(|forceStrobe), overflow, ch3Fire};
	wire [gfc_pkg::IRQ_N-1:0] irqClr =
		wrIrqClr ? wData[gfc_pkg::IRQ_N-1:0] : '0;
	wire [gfc_pkg::IRQ_N-1:0] nextStatus = (irqStatus & ~irqClr) | irqEvent;
	wire [gfc_pkg::IRQ_N-1:0] nextIrqEn =
		wrIrqEn ? wData[gfc_pkg::IRQ_N-1:0] : irqEnable;

	gfc_prescaler #(
		.PRE_W(PW)
	) u_prescaler (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.enable(timerEnable),
		.restart(countLoad),
		.sel(prescaleSel),
		.tick(tick)
	);

	gfc_counter #(
		.CNT_W(CW)
	) u_counter (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tick(tick),
		.load(countLoad),
		.loadValue(wData[CW-1:0]),
		.count(count),
		.overflow(overflow)
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			wStrb <= '0;
		end else begin
			if (awTake) begin
				awAddr <= s_axi_awaddr;
			end
			if (wTake) begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			s_axi_awready <= wrFire | (s_axi_awready & !awTake);
			s_axi_wready <= wrFire | (s_axi_wready & !wTake);
			s_axi_bvalid <= wrFire | (s_axi_bvalid & !s_axi_bready);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
		end else begin
			if (arTake) begin
				s_axi_rdata <= readMux;
			end
			s_axi_rvalid <= arTake | (s_axi_rvalid & !s_axi_rready);
			s_axi_arready <= (s_axi_rvalid & s_axi_rready) |
				(s_axi_arready & !arTake);
		end
	end

	assign s_axi_bresp = gfc_pkg::RESP_OKAY;
	assign s_axi_rresp = gfc_pkg::RESP_OKAY;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			channelModeSelect <= gfc_pkg::CH_RESET;
			forceCompareBits <= gfc_pkg::CH_RESET;
			channel3OverrideMaskBits <= gfc_pkg::CH_RESET;
			channel3OverrideDataBits <= gfc_pkg::CH_RESET;
			toggleOnOverflowEnable <= gfc_pkg::CH_RESET;
			timerPortDirectionBits <= gfc_pkg::CH_RESET;
		end else begin
			channelModeSelect <= wrMode ? wrLow : channelModeSelect;
			forceCompareBits <= wrForce ? wrLow : forceCompareBits;
			channel3OverrideMaskBits <=
				wrMask ? wrLow : channel3OverrideMaskBits;
			channel3OverrideDataBits <=
				wrData ? wrLow : channel3OverrideDataBits;
			toggleOnOverflowEnable <= wrTov ? wrLow : toggleOnOverflowEnable;
			timerPortDirectionBits <=
				wrDdr ? wrLow : timerPortDirectionBits;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			testMode <= 1'b0;
			timerEnable <= 1'b0;
			prescaleSel <= '0;
			irqStatus <= '0;
			irqEnable <= '0;
			irq <= 1'b0;
		end else begin
			testMode <= wrTest ? wData[gfc_pkg::TEST_MODE_BIT] : testMode;
			timerEnable <= wrCtrl ? wData[gfc_pkg::CTRL_EN_BIT] : timerEnable;
			prescaleSel <= wrCtrl ? wData[gfc_pkg::CTRL_PRE_LSB +: PW] :
				prescaleSel;
			irqStatus <= nextStatus;
			irqEnable <= nextIrqEn;
			irq <= |(nextStatus & nextIrqEn);
		end
	end

	// pins: hardware compare events win over a same-cycle port write
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			timerPortPinOut <= gfc_pkg::CH_RESET;
			timerPortPinOe <= gfc_pkg::CH_RESET;
			compareFlagSet <= gfc_pkg::CH_RESET;
			countValueField <= gfc_pkg::CNT_RESET;
		end else begin
			timerPortPinOut <= nextPort;
			timerPortPinOe <= nextOe;
			compareFlagSet <= nextFlag;
			countValueField <= count;
		end
	end

	// pin input is not used here; capture lives elsewhere in the timer
	wire unusedPinIn = ^timerPortPinIn;
endmodule : gfc_force_compare

// ### gfc_force_compare_properties.sv
`timescale 1ns/1ns
module gfc_force_compare_properties (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] compareMatch,
	input wire logic [3:0] timerPortPinOut,
	input wire logic [3:0] compareFlagSet,
	input wire logic [15:0] countValueField
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready
		|=> !s_axi_awready) else $error("aw taken twice");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready && !s_axi_bvalid
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("bvalid dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r moved");
	a_resp_okay: assert property (s_axi_bvalid || s_axi_rvalid
		|-> (s_axi_bresp | s_axi_rresp) == gfc_pkg::RESP_OKAY)
		else $error("bad response");
	a_flag_cause: assert property (
		(compareFlagSet & ~$past(compareMatch)) == 4'h0)
		else $error("flag without match");
	a_pin_cause: assert property ($changed(timerPortPinOut)
		|-> $past(compareMatch) != 4'h0 || $rose(s_axi_bvalid) ||
		(countValueField == 16'h0000 && $past(countValueField) == 16'hFFFF))
		else $error("pin moved without cause");
	a_count_step: assert property (
		$changed(countValueField) && !$past(s_axi_bvalid)
		|-> countValueField == $past(countValueField) + 16'h0001)
		else $error("count jumped");
endmodule : gfc_force_compare_properties
bind gfc_force_compare gfc_force_compare_properties chk (.*);

// ### gfc_pin_model.sv
`timescale 1ns/1ns
module gfc_pin_model (
	input wire logic [3:0] pinOut,
	input wire logic [3:0] pinOe,
	output logic [3:0] pinLevel
);
	// undriven pins float to the pull-up, not to a stale value
	assign pinLevel = (pinOut & pinOe) | ~pinOe;
endmodule : gfc_pin_model

// ### gfc_force_compare_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
	$display("BAD %0t got %0h exp %0h", $time, a, b); end end
module gfc_force_compare_tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00, cAct = 8'h00;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
	logic arValid = 1'b0, rReady = 1'b0;
	logic [31:0] wData = 32'h0, rv;
	logic [3:0] cMatch = 4'h0, f, h;
	wire logic awReady, wReady, bValid, arReady, rValid, irq;
	wire logic [1:0] bResp, rResp;
	wire logic [31:0] rData;
	wire logic [3:0] pinOut, pinOe, flagSet, pinLevel;
	wire logic [15:0] cnt;
	// mode, mask, data, direction, port
	logic [3:0] m [5];
	logic [5:0] idx [5];
	int err_total = 0, comparisons = 0, cyc = 0;
	gfc_force_compare dut (.core_clk(core_clk), .rst_b(rst_b),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .compareMatch(cMatch), .compareAction(cAct),
		.timerPortPinIn(pinLevel), .timerPortPinOut(pinOut),
		.timerPortPinOe(pinOe), .compareFlagSet(flagSet),
		.countValueField(cnt), .irq(irq));
	gfc_pin_model pins (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));
	initial forever #2 core_clk = ~core_clk;
	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		@(posedge core_clk);
		awAddr <= {i, 2'b00};
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
		end while (!bValid);
		bReady <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] i);
		@(posedge core_clk);
		arAddr <= {i, 2'b00};
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arReady) arValid <= 1'b0;
		end while (!rValid);
		rv = rData;
		rReady <= 1'b0;
	endtask : rd
	// set beats toggle when both bits of an action are considered
	function automatic logic [3:0] act(input logic [3:0] p, input logic [3:0] s);
		logic [3:0] r;
		r = p;
		for (int n = 0; n < 4; n++) begin
			if (s[n] && cAct[2*n+:2] == 2'h1) r[n] = ~p[n];
			if (s[n] && cAct[2*n+1]) r[n] = cAct[2*n];
		end
		return r;
	endfunction : act
	task pins_chk;
		@(negedge core_clk);
		`CHK(pinOut, m[4])
		`CHK(pinOe, m[3] | (m[1] & m[0]))
	endtask : pins_chk
	initial begin
		idx = '{gfc_pkg::IDX_MODE, gfc_pkg::IDX_MASK, gfc_pkg::IDX_DATA,
			gfc_pkg::IDX_DDR, gfc_pkg::IDX_PORT};
		void'($urandom(32'hE9A4));
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) begin
			foreach (m[k]) begin
				m[k] = 4'($urandom());
				wr(idx[k], {28'h0, m[k]});
			end
			pins_chk();
			foreach (m[k]) begin
				rd(idx[k]);
				`CHK(rv, {28'h0, m[k]})
			end
		end
		rd(6'h3F);
		`CHK(rv, 32'h0)
		$display("test registers done");
		@(posedge core_clk);
		cAct <= 8'($urandom());
		f = 4'($urandom()) | 4'h1;
		wr(gfc_pkg::IDX_FORCE, {28'h0, f});
		m[4] = act(m[4], f & m[0]);
		pins_chk();
		wr(gfc_pkg::IDX_FORCE, 32'h0);
		pins_chk();
		rd(gfc_pkg::IDX_IRQ_STAT);
		`CHK(rv, 32'h4)
		`CHK(irq, 1'b0)
		wr(gfc_pkg::IDX_IRQ_EN, 32'h4);
		@(negedge core_clk);
		`CHK(irq, 1'b1)
		wr(gfc_pkg::IDX_IRQ_CLR, 32'h4);
		@(negedge core_clk);
		`CHK(irq, 1'b0)
		$display("test force done");
		repeat (8) begin
			for (int k = 0; k < 3; k++) begin
				m[k] = 4'($urandom());
				wr(idx[k], {28'h0, m[k]});
			end
			h = 4'($urandom());
			@(posedge core_clk);
			cAct <= 8'($urandom());
			cMatch <= h;
			@(posedge core_clk);
			cMatch <= 4'h0;
			m[4] = act(m[4], h & m[0]);
			if (h[3] && m[0][3]) m[4] = (m[4] & ~m[1]) | (m[2] & m[1]);
			pins_chk();
			`CHK(flagSet, h & m[0])
		end
		$display("test override done");
		rd(gfc_pkg::IDX_COUNT);
		`CHK(rv, 32'h0)
		wr(gfc_pkg::IDX_COUNT, 32'h1234);
		rd(gfc_pkg::IDX_COUNT);
		`CHK(rv, 32'h0)
		wr(gfc_pkg::IDX_TEST, 32'h1);
		wr(gfc_pkg::IDX_COUNT, 32'hFFFD);
		rd(gfc_pkg::IDX_COUNT);
		`CHK(rv, 32'hFFFD)
		`CHK(cnt, 16'hFFFD)
		wr(gfc_pkg::IDX_TOV, 32'hF);
		wr(gfc_pkg::IDX_CTRL, 32'h1);
		repeat (20) @(posedge core_clk);
		wr(gfc_pkg::IDX_CTRL, 32'h0);
		m[4] = m[4] ^ m[0];
		pins_chk();
		rd(gfc_pkg::IDX_IRQ_STAT);
		`CHK(rv[1], 1'b1)
		rd(gfc_pkg::IDX_COUNT);
		`CHK(rv[15:0] < 16'h0040, 1'b1)
		`CHK(cnt, rv[15:0])
		$display("test counter done");
		complete_run();
	end
endmodule : gfc_force_compare_tb
